/* File: hw/mcg_top.sv */
// Purpose: microcycle clock generation, hold and gating around bus slave and master cycles
// Assumes: microinstruction fields and datapath words are on clk_sys; bus pins are not
// Notes:   bus pins pass two flops; open-collector pins are split into out and oe_n
`timescale 1ns/100ps
`include "mcg_params.svh"

module mcg_fifo #(
   parameter int W = 16,
   parameter int D = 32
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_reg [D];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0]   cnt_reg;
   logic          push;
   logic          pop;

   // depth is a power of two so the pointers wrap by themselves
   assign in_ready  = (cnt_reg != (AW+1)'(D));
   assign out_valid = (cnt_reg != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_reg[rd_ptr_reg];

   // storage, data only so no reset
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
         if (pop) rd_ptr_reg <= rd_ptr_reg + AW'(1);
         if (push && !pop) cnt_reg <= cnt_reg + (AW+1)'(1);
         else if (pop && !push) cnt_reg <= cnt_reg - (AW+1)'(1);
      end
   end
endmodule

// Notes on behaviour
// - inhibited clock waits in hold, then resumes
// - answer slave only with enable and address match
// - slave access traps by direction and word
// - slave read drives accumulator word; finish code 00
// - finish drops finish hold and asserts terminate
// - state frozen until go removed; then restart
// - slave write word captured; clock held until go
// - master command loads upper address, connects FIFO
// - special field 0001 holds clock until cycle done
// - 20 us timeout clears master logic, restarts clock
// - word select enables upper, lower or both
// - lower select kills upper clock, and vice versa
// - clock stop bit suppresses slice clock pulse
// - trap fetch suppresses slice clock pulse
// - source enable low 100 ns after rising edge
// - enable latch transparent unless master cycle active
// - one 16-bit word with 20-bit address
// - masters resolved by position; may reserve next
// - master drives address, handshakes every word
// - slave active only inside its address range
// - eight words from base to base plus 7
// - each data word is its own master cycle
// - mode changes without glitches or lost cycles
// - free-running period is 300 ns
module mcg_top
   import mcg_pkg::*;
(
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // microinstruction fields
   input  wire logic                    uinstr_slave_enable,
   input  wire logic [1:0]              uinstr_bus_cmd,
   input  wire logic [3:0]              uinstr_special,
   input  wire logic [1:0]              uinstr_word_select,
   input  wire logic                    uinstr_clock_stop,
   input  wire logic                    trap_taken,
   // datapath words
   input  wire logic [`MCG_DATA_W-1:0]  accum_data,
   input  wire logic [15:0]             slice_addr_low,
   input  wire logic [`MCG_UPPER_W-1:0] addr_upper_in,
   input  wire logic [`MCG_DATA_W-1:0]  master_write_data,
   // pins: switches, test and grant
   input  wire logic [`MCG_ADDR_W-1:0]  base_addr,
   input  wire logic                    clock_inhibit,
   input  wire logic                    bus_grant,
   // bus pins
   input  wire logic                    bus_go_n_in,
   output logic                         bus_go_n_out,
   output logic                         bus_go_oe_n,
   input  wire logic                    bus_read_in,
   output logic                         bus_read_out,
   input  wire logic [`MCG_ADDR_W-1:0]  bus_addr_in,
   output logic [`MCG_ADDR_W-1:0]       bus_addr_out,
   output logic                         bus_addr_oe_n,
   input  wire logic [`MCG_DATA_W-1:0]  bus_data_in,
   output logic [`MCG_DATA_W-1:0]       bus_data_out,
   output logic                         bus_data_oe_n,
   input  wire logic                    bus_terminate_n_in,
   output logic                         bus_terminate_n_out,
   output logic                         bus_terminate_oe_n,
   // clocks to sequencer and slices
   output logic                         microcycle_clock_n,
   output logic                         upper_half_clock_n,
   output logic                         lower_half_clock_n,
   output logic                         internal_bus_source_enable,
   output logic                         internal_bus_source_enable_latched,
   // slave trap to sequencer
   output logic                         slave_trap_req,
   output logic                         slave_trap_read,
   output logic [2:0]                   slave_trap_word,
   output logic [`MCG_DATA_W-1:0]       slave_write_data,
   output logic                         slave_finish_hold_n,
   // master status
   output logic                         master_cycle_active_n,
   output logic                         master_cycle_clock_hold_n,
   output logic                         master_timeout_error,
   input  wire logic                    error_clear,
   // read data stream toward disk path
   output logic                         rd_fifo_valid,
   input  wire logic                    rd_fifo_ready,
   output logic [`MCG_DATA_W-1:0]       rd_fifo_data
);
   localparam int SW = 61;
   localparam logic [5:0]  N_PULSE  = 6'(`MCG_N_PULSE);
   localparam logic [5:0]  N_GAP    = 6'(`MCG_N_GAP);
   localparam logic [5:0]  N_SETTLE = 6'(`MCG_N_SETTLE);
   localparam logic [11:0] N_TO     = 12'(`MCG_N_TIMEOUT);

   logic [SW-1:0]           sync1_reg;
   logic [SW-1:0]           sync2_reg;
   logic                    go_q;
   logic                    read_q;
   logic [`MCG_ADDR_W-1:0]  addr_q;
   logic [`MCG_DATA_W-1:0]  data_q;
   logic                    term_q;
   logic                    grant_q;
   logic                    test_inh_q;
   logic [`MCG_ADDR_W-1:0]  base_q;
   logic                    go_d_reg;

   mcg_clk_e                st_reg;
   mcg_clk_e                st_next;
   logic [5:0]              ph_reg;
   logic [5:0]              ph_next;
   logic                    inh_any;
   logic                    cyc_end;
   logic                    mclk_n_reg;
   logic                    up_n_reg;
   logic                    lo_n_reg;
   logic                    ibse_reg;
   logic                    ibsel_reg;
   logic                    ibse_next;

   logic [`MCG_ADDR_W-1:0]  slv_off;
   logic                    slv_match;
   logic                    slv_start;
   logic                    slv_fin;
   logic                    slv_act_reg;
   logic                    slv_hold_reg;
   logic                    slv_read_reg;
   logic [2:0]              slv_word_reg;
   logic [`MCG_DATA_W-1:0]  slv_wdata_reg;
   logic [`MCG_DATA_W-1:0]  slv_rdata_reg;

   logic                    mst_cmd;
   logic                    mst_stall;
   logic                    mst_start;
   logic                    mst_done;
   logic                    mst_to;
   logic                    mst_busy_reg;
   logic                    mst_go_reg;
   logic                    mst_read_reg;
   logic                    mst_hold_reg;
   logic [11:0]             to_cnt_reg;
   logic [`MCG_UPPER_W-1:0] mst_upper_reg;
   logic [15:0]             mst_low_reg;
   logic [`MCG_DATA_W-1:0]  mst_wdata_reg;
   logic                    err_reg;
   logic                    fifo_in_ready;
   logic                    lower_sel_n;
   logic                    upper_sel_n;
   logic                    slice_sup;

   // every pin goes through two flops; active-low pins inverted so reset is all zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {~bus_go_n_in, bus_read_in, bus_addr_in, bus_data_in,
                       ~bus_terminate_n_in, bus_grant, clock_inhibit, base_addr};
         sync2_reg <= sync1_reg;
      end
   end
   assign {go_q, read_q, addr_q, data_q, term_q, grant_q, test_inh_q, base_q} = sync2_reg;

   // clock is held by test, by a finished slave cycle, by a held master cycle,
   // or by a master command that cannot start yet, unless a slave cycle is pending
   assign inh_any = test_inh_q | slv_hold_reg | mst_hold_reg | mst_stall;
   assign cyc_end = (st_reg == MCG_ST_PULSE) && (ph_reg == N_PULSE - 6'h1);

   // clock generator: pulse, gap, then hold while inhibited; the hold exits straight
   // into a full pulse so no runt pulse and no lost microcycle can appear
   always_comb begin
      st_next = st_reg;
      ph_next = ph_reg + 6'h1;
      unique case (st_reg)
         MCG_ST_PULSE: begin
            if (ph_reg == N_PULSE - 6'h1) begin
               st_next = MCG_ST_GAP;
               ph_next = 6'h0;
            end
         end
         MCG_ST_GAP: begin
            if (ph_reg == N_GAP - 6'h1) begin
               st_next = inh_any ? MCG_ST_HOLD : MCG_ST_PULSE;
               ph_next = 6'h0;
            end
         end
         MCG_ST_HOLD: begin
            ph_next = 6'h0;
            if (!inh_any) st_next = MCG_ST_PULSE;
         end
         default: begin
            st_next = MCG_ST_GAP;
            ph_next = 6'h0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= MCG_ST_GAP;
         ph_reg <= 6'h0;
      end else begin
         st_reg <= st_next;
         ph_reg <= ph_next;
      end
   end

   // half selects and slice clock suppression
   assign lower_sel_n = (uinstr_word_select != `MCG_WS_LOWER);
   assign upper_sel_n = (uinstr_word_select != `MCG_WS_UPPER);
   assign slice_sup   = uinstr_clock_stop | trap_taken;

   // all clocks come from flops loaded on the same edge, so they coincide
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mclk_n_reg <= 1'b1;
         up_n_reg   <= 1'b1;
         lo_n_reg   <= 1'b1;
      end else begin
         mclk_n_reg <= (st_next != MCG_ST_PULSE);
         up_n_reg   <= !((st_next == MCG_ST_PULSE) && lower_sel_n && !slice_sup);
         lo_n_reg   <= !((st_next == MCG_ST_PULSE) && upper_sel_n && !slice_sup);
      end
   end

   // source enable waits out the sequencer settling after each rising edge
   assign ibse_next = ((st_next == MCG_ST_GAP) && (ph_next >= N_SETTLE)) ||
                      (st_next == MCG_ST_HOLD);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ibse_reg  <= 1'b0;
         ibsel_reg <= 1'b0;
      end else begin
         ibse_reg <= ibse_next;
         if (!mst_busy_reg) ibsel_reg <= ibse_next;
      end
   end

   // slave decode: eight words from base, strobed on the go edge
   assign slv_off   = addr_q - base_q;
   assign slv_match = (addr_q >= base_q) && (slv_off < `MCG_SLV_SPAN);
   assign slv_start = go_q && !go_d_reg && uinstr_slave_enable && slv_match &&
                      !slv_act_reg && !mst_busy_reg;
   // finish code decodes only at the microcycle edge of a pending slave cycle
   assign slv_fin   = cyc_end && slv_act_reg && !slv_hold_reg &&
                      (uinstr_bus_cmd == `MCG_CMD_SLV_FIN);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         go_d_reg      <= 1'b0;
         slv_act_reg   <= 1'b0;
         slv_hold_reg  <= 1'b0;
         slv_read_reg  <= 1'b0;
         slv_word_reg  <= 3'h0;
         slv_wdata_reg <= '0;
         slv_rdata_reg <= '0;
      end else begin
         go_d_reg <= go_q;
         if (slv_start) begin
            slv_act_reg   <= 1'b1;
            slv_read_reg  <= read_q;
            slv_word_reg  <= slv_off[2:0];
            slv_wdata_reg <= data_q;
         end else if (!go_q) begin
            slv_act_reg  <= 1'b0;
            slv_hold_reg <= 1'b0;
         end else if (slv_fin) begin
            slv_hold_reg  <= 1'b1;
            slv_rdata_reg <= accum_data;
         end
      end
   end

   // master command: a second command waits on the clock, not in a queue
   assign mst_cmd   = cyc_end ? 1'b0 : 1'b0;
   assign mst_stall = ((uinstr_bus_cmd == `MCG_CMD_MST_RD) ||
                       (uinstr_bus_cmd == `MCG_CMD_MST_WR)) && !slv_act_reg &&
                      (mst_busy_reg || ((uinstr_bus_cmd == `MCG_CMD_MST_RD) && !fifo_in_ready));
   assign mst_start = cyc_end && !slv_act_reg && !mst_busy_reg && !mst_cmd &&
                      ((uinstr_bus_cmd == `MCG_CMD_MST_WR) ||
                       ((uinstr_bus_cmd == `MCG_CMD_MST_RD) && fifo_in_ready));
   assign mst_done  = mst_go_reg && term_q;
   assign mst_to    = mst_busy_reg && (to_cnt_reg == N_TO - 12'h1);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mst_busy_reg  <= 1'b0;
         mst_go_reg    <= 1'b0;
         mst_read_reg  <= 1'b0;
         mst_hold_reg  <= 1'b0;
         mst_upper_reg <= '0;
         mst_low_reg   <= '0;
         mst_wdata_reg <= '0;
      end else if (mst_start) begin
         mst_busy_reg  <= 1'b1;
         mst_read_reg  <= (uinstr_bus_cmd == `MCG_CMD_MST_RD);
         mst_hold_reg  <= (uinstr_special == `MCG_SPC_MST_HOLD);
         mst_upper_reg <= addr_upper_in;
         mst_low_reg   <= slice_addr_low;
         mst_wdata_reg <= master_write_data;
      end else if (mst_done || mst_to) begin
         mst_busy_reg <= 1'b0;
         mst_go_reg   <= 1'b0;
         mst_hold_reg <= 1'b0;
      end else if (mst_busy_reg && grant_q && !term_q) begin
         mst_go_reg <= 1'b1;
      end
   end

   // hang timer restarts with every master cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) to_cnt_reg <= 12'h0;
      else if (mst_start || !mst_busy_reg) to_cnt_reg <= 12'h0;
      else to_cnt_reg <= to_cnt_reg + 12'h1;
   end

   // sticky error; a timeout in the clearing cycle still sets it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) err_reg <= 1'b0;
      else if (mst_to) err_reg <= 1'b1;
      else if (error_clear) err_reg <= 1'b0;
   end

   // read words from the bus wait here for the disk path; full stalls the clock
   mcg_fifo #(
      .W (`MCG_DATA_W),
      .D (`MCG_FIFO_DEPTH)
   ) u_rd_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (mst_done && mst_read_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (data_q),
      .out_valid (rd_fifo_valid),
      .out_ready (rd_fifo_ready),
      .out_data  (rd_fifo_data)
   );

   // bus drivers; open-collector pins pull low only through their enables
   assign bus_go_n_out        = 1'b0;
   assign bus_go_oe_n         = !mst_go_reg;
   assign bus_read_out        = mst_read_reg;
   assign bus_addr_out        = {mst_upper_reg, mst_low_reg};
   assign bus_addr_oe_n       = !mst_go_reg;
   assign bus_data_out        = slv_read_reg ? slv_rdata_reg : mst_wdata_reg;
   assign bus_data_oe_n       = !((slv_hold_reg && slv_read_reg) ||
                                  (mst_go_reg && !mst_read_reg));
   assign bus_terminate_n_out = 1'b0;
   assign bus_terminate_oe_n  = !slv_hold_reg;

   // outputs to sequencer and slices
   assign microcycle_clock_n                 = mclk_n_reg;
   assign upper_half_clock_n                 = up_n_reg;
   assign lower_half_clock_n                 = lo_n_reg;
   assign internal_bus_source_enable         = ibse_reg;
   assign internal_bus_source_enable_latched = ibsel_reg;
   assign slave_trap_req                     = slv_act_reg && !slv_hold_reg;
   assign slave_trap_read                    = slv_read_reg;
   assign slave_trap_word                    = slv_word_reg;
   assign slave_write_data                   = slv_wdata_reg;
   assign slave_finish_hold_n                = !slv_hold_reg;
   assign master_cycle_active_n              = !mst_busy_reg;
   assign master_cycle_clock_hold_n          = !mst_hold_reg;
   assign master_timeout_error               = err_reg;

   // checks
   sequence s_pulse_full;
      !mclk_n_reg ##15 !mclk_n_reg ##1 mclk_n_reg;
   endsequence
   sequence s_restart;
      ##[1:50] !mclk_n_reg;
   endsequence

   pulse_width_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(mclk_n_reg) |-> s_pulse_full) else $error("pulse width wrong");
   free_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_reg == MCG_ST_GAP && ph_reg == 6'h2b && !inh_any) |=> ##1 !mclk_n_reg)
      else $error("free-running period wrong");
   hold_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_reg == MCG_ST_HOLD && inh_any) |=> mclk_n_reg) else $error("pulse while held");
   slave_fin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      slv_fin && go_q |=> !slave_finish_hold_n && !bus_terminate_oe_n)
      else $error("finish did not hold and terminate");
   go_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (slv_hold_reg && !go_q && !test_inh_q && !mst_hold_reg) |=>
      (slave_finish_hold_n && bus_terminate_oe_n) ##0 s_restart)
      else $error("no restart after go released");
   slave_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(slv_act_reg) |-> $past(uinstr_slave_enable) && $past(go_q) && !$past(go_d_reg))
      else $error("slave answered without enable");
   master_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mst_hold_reg && st_reg == MCG_ST_HOLD) |-> mclk_n_reg && !master_cycle_active_n)
      else $error("clock ran during held master cycle");
   timeout_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mst_to |=> master_cycle_active_n && master_timeout_error && master_cycle_clock_hold_n)
      else $error("timeout did not clear master cycle");
   settle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(mclk_n_reg) |-> !ibse_reg ##19 !ibse_reg ##1 ibse_reg)
      else $error("source enable settle wrong");
   half_sync_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!upper_half_clock_n || !lower_half_clock_n) |-> !microcycle_clock_n)
      else $error("half clock outside microcycle pulse");
   suppress_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ($fell(mclk_n_reg) && $past(slice_sup)) |-> upper_half_clock_n && lower_half_clock_n)
      else $error("slice clock not suppressed");
   latch_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ($past(mst_busy_reg) && mst_busy_reg) |-> $stable(internal_bus_source_enable_latched))
      else $error("enable latch moved in master cycle");
endmodule

/* File: include/mcg_params.svh */
// Purpose: constants for the microcycle clock and bus cycle gating block
// Assumes: clk_sys period of 5 ns
// Notes:   counts here are derived from times; the assertion and bench cycle counts are written for 5 ns
`ifndef MCG_PARAMS_SVH
`define MCG_PARAMS_SVH
`define MCG_CLK_NS        5
`define MCG_T_PERIOD_NS   300
`define MCG_T_PULSE_NS    80
`define MCG_T_SETTLE_NS   100
`define MCG_T_TIMEOUT_US  20
`define MCG_N_PERIOD      (`MCG_T_PERIOD_NS / `MCG_CLK_NS)
`define MCG_N_PULSE       ((`MCG_T_PULSE_NS + `MCG_CLK_NS - 1) / `MCG_CLK_NS)
`define MCG_N_GAP         (`MCG_N_PERIOD - `MCG_N_PULSE)
`define MCG_N_SETTLE      ((`MCG_T_SETTLE_NS + `MCG_CLK_NS - 1) / `MCG_CLK_NS)
`define MCG_N_TIMEOUT     ((`MCG_T_TIMEOUT_US * 1000 + `MCG_CLK_NS - 1) / `MCG_CLK_NS)
`define MCG_CMD_SLV_FIN   2'h0
`define MCG_CMD_MST_RD    2'h1
`define MCG_CMD_MST_WR    2'h2
`define MCG_SPC_MST_HOLD  4'h1
`define MCG_WS_LOWER      2'h1
`define MCG_WS_UPPER      2'h2
`define MCG_SLV_SPAN      20'h8
`define MCG_FIFO_DEPTH    32
`define MCG_DATA_W        16
`define MCG_ADDR_W        20
`define MCG_UPPER_W       4
`endif

/* File: include/mcg_pkg.sv */
// Purpose: types shared by the microcycle clock gating design
// Assumes: constants come from mcg_params.svh
// Notes:   one-hot state codes are written out
package mcg_pkg;
   typedef enum logic [2:0] {
      MCG_ST_PULSE = 3'h1,
      MCG_ST_GAP   = 3'h2,
      MCG_ST_HOLD  = 3'h4
   } mcg_clk_e;
endpackage

/* File: dv/mcg_mem_model.sv */
// Purpose: memory slave on the far side of the master bus cycles
// Assumes: go and terminate are active-low open-collector lines
// Notes:   stall never terminates, so the hang timeout can be reached
`timescale 1ns/100ps
module mcg_mem_model (
   // clock and control
   input  wire logic        clk_sys,
   input  wire logic        stall,
   // bus side
   input  wire logic        bus_go_oe_n,
   input  wire logic [19:0] bus_addr_out,
   output logic             mem_term_n = 1'b1,
   output logic [15:0]      mem_data,
   output logic [19:0]      mem_addr = 20'h0
);
   logic [2:0] dly_reg = 3'h0;
   // read word follows the address; a released line shows its inverse
   assign mem_data = (mem_addr[15:0] ^ 16'ha5a5) ^ {16{mem_term_n}};
   // one word per go, terminate held until go drops
   always @(posedge clk_sys) begin
      mem_addr   <= bus_go_oe_n ? mem_addr : bus_addr_out;
      dly_reg    <= bus_go_oe_n ? 3'h0 : dly_reg + {2'h0, dly_reg != 3'h4};
      mem_term_n <= bus_go_oe_n | stall | (dly_reg != 3'h4);
   end
endmodule

/* File: dv/tb.sv */
// Purpose: bench for clock gating around slave and master bus cycles
// Assumes: the bench plays the host, mcg_mem_model the memory
// Notes:   slave base is fixed and arbitration always grants
`timescale 1ns/100ps
`include "mcg_params.svh"
module tb;
   logic clk_sys = 1'b0, rst_n = 1'b0, stall = 1'b0, host_go_n = 1'b1, host_read;
   logic uinstr_slave_enable = 1'b1, uinstr_clock_stop = 1'b0, trap_taken = 1'b0;
   logic clock_inhibit = 1'b0, bus_grant = 1'b1, error_clear = 1'b0, rd_fifo_ready = 1'b0;
   logic [1:0] uinstr_bus_cmd = 2'h3, uinstr_word_select = `MCG_WS_LOWER, slave_trap_word_x;
   logic [3:0] uinstr_special = `MCG_SPC_MST_HOLD, addr_upper_in = 4'h9;
   logic [15:0] accum_data = 16'h1e2d, slice_addr_low = 16'h4a70, master_write_data = 16'h0ff1;
   logic [15:0] mem_data, bus_data_out, slave_write_data, rd_fifo_data;
   logic [19:0] base_addr = 20'h00150, host_addr = 20'h0, bus_addr_out, mem_addr;
   logic mem_term_n, bus_go_n_out, bus_go_oe_n, bus_read_out, bus_addr_oe_n, bus_data_oe_n;
   logic bus_terminate_n_out, bus_terminate_oe_n, microcycle_clock_n, upper_half_clock_n;
   logic lower_half_clock_n, internal_bus_source_enable, internal_bus_source_enable_latched;
   logic slave_trap_req, slave_trap_read, slave_finish_hold_n, master_cycle_active_n;
   logic master_cycle_clock_hold_n, master_timeout_error, rd_fifo_valid;
   logic [2:0] slave_trap_word;
   int n_fail = 0, checked = 0, w;
   // open-collector lines are low when any party pulls
   wire bus_go_n_in = bus_go_oe_n & host_go_n;
   wire bus_terminate_n_in = bus_terminate_oe_n & mem_term_n;
   wire bus_read_in = bus_addr_oe_n ? host_read : bus_read_out;
   wire [19:0] bus_addr_in = bus_addr_oe_n ? host_addr : bus_addr_out;
   wire [15:0] bus_data_in = !bus_data_oe_n ? bus_data_out : (host_go_n ? mem_data : 16'h3c5a);
   always #2.5 clk_sys = ~clk_sys;
   mcg_top mcg_top_i (.clk_sys, .rst_n, .uinstr_slave_enable, .uinstr_bus_cmd, .uinstr_special,
      .uinstr_word_select, .uinstr_clock_stop, .trap_taken, .accum_data, .slice_addr_low,
      .addr_upper_in, .master_write_data, .base_addr, .clock_inhibit, .bus_grant, .bus_go_n_in,
      .bus_go_n_out, .bus_go_oe_n, .bus_read_in, .bus_read_out, .bus_addr_in, .bus_addr_out,
      .bus_addr_oe_n, .bus_data_in, .bus_data_out, .bus_data_oe_n, .bus_terminate_n_in,
      .bus_terminate_n_out, .bus_terminate_oe_n, .microcycle_clock_n, .upper_half_clock_n,
      .lower_half_clock_n, .internal_bus_source_enable, .internal_bus_source_enable_latched,
      .slave_trap_req, .slave_trap_read, .slave_trap_word, .slave_write_data,
      .slave_finish_hold_n, .master_cycle_active_n, .master_cycle_clock_hold_n,
      .master_timeout_error, .error_clear, .rd_fifo_valid, .rd_fifo_ready, .rd_fifo_data);
   mcg_mem_model mcg_mem_model_i (.clk_sys, .stall, .bus_go_oe_n, .bus_addr_out, .mem_term_n,
      .mem_data, .mem_addr);
   // inputs move 1 ns after the edge; w counts cycles for bounded waits
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
      w += k;
   endtask
   task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // a wait that ran out ends the run
   task automatic lim;
      if (w >= 4200) begin
         n_fail++;
         conclude;
      end
   endtask
   // host slave access; on a hit go is held until terminate, as the bus demands; a miss drops go after 20 cycles
   task automatic slv(input logic [19:0] a, input logic rd, input logic hit);
      host_addr = a;
      host_read = rd;
      host_go_n = 1'b0;
      tick(20);
      chk("trap", slave_trap_req, hit);
      if (hit) begin
         chk("word", slave_trap_word, a[2:0]);
         chk("dir", slave_trap_read, rd);
         if (!rd) chk("wdata", slave_write_data, 16'h3c5a);
         uinstr_bus_cmd = `MCG_CMD_SLV_FIN;
         w = 0;
         while (bus_terminate_oe_n !== 1'b0 && w < 4200) tick(1);
         lim();
         uinstr_bus_cmd = 2'h3;
         chk("fhold", slave_finish_hold_n, 1'b0);
         if (rd) chk("rdata", bus_data_out, accum_data);
         tick(30);
         chk("frozen", microcycle_clock_n, 1'b1);
      end
      host_go_n = 1'b1;
      w = 0;
      while (microcycle_clock_n !== 1'b0 && w < 4200) tick(1);
      chk("restart", w <= 60, 1'b1);
      chk("release", bus_terminate_oe_n, 1'b1);
   endtask
   // one master word; stall makes the memory hang
   task automatic mst(input logic [1:0] cmd, input logic st);
      stall = st;
      uinstr_bus_cmd = cmd;
      w = 0;
      while (master_cycle_active_n !== 1'b0 && w < 4200) tick(1);
      lim();
      uinstr_bus_cmd = 2'h3;
      chk("mhold", master_cycle_clock_hold_n, 1'b0);
      tick(70);
      chk("mfrozen", microcycle_clock_n, 1'b1);
      w = 0;
      while (master_cycle_active_n === 1'b0 && w < 4200) tick(1);
      lim();
      chk("timeout", master_timeout_error, st);
      chk("maddr", mem_addr, {addr_upper_in, slice_addr_low});
      w = 0;
      while (rd_fifo_valid !== 1'b1 && w < 20) tick(1);
      if (cmd == `MCG_CMD_MST_RD && !st) chk("mrd", rd_fifo_data, slice_addr_low ^ 16'ha5a5);
      rd_fifo_ready = 1'b1;
      tick(1);
      rd_fifo_ready = 1'b0;
      w = 0;
      while (microcycle_clock_n !== 1'b0 && w < 4200) tick(1);
      chk("mrestart", w <= 60, 1'b1);
   endtask
   initial begin
      tick(3);
      rst_n = 1'b1;
      w = 0;
      while (microcycle_clock_n !== 1'b0 && w < 4200) tick(1);
      lim();
      chk("ibse0", internal_bus_source_enable, 1'b0);
      chk("upper", upper_half_clock_n, 1'b1);
      chk("lower", lower_half_clock_n, 1'b0);
      w = 0;
      while (microcycle_clock_n === 1'b0 && w < 4200) tick(1);
      chk("pulse", w, `MCG_N_PULSE);
      tick(19);
      chk("settle", internal_bus_source_enable, 1'b0);
      tick(2);
      chk("ibse1", internal_bus_source_enable, 1'b1);
      uinstr_clock_stop = 1'b1;
      while (microcycle_clock_n !== 1'b0 && w < 4200) tick(1);
      chk("period", w, `MCG_N_PERIOD);
      chk("stop", lower_half_clock_n, 1'b1);
      uinstr_clock_stop = 1'b0;
      slv(base_addr + 20'h3, 1'b1, 1'b1);
      slv(base_addr + 20'h7, 1'b0, 1'b1);
      slv(base_addr + 20'h8, 1'b1, 1'b0);
      uinstr_slave_enable = 1'b0;
      slv(base_addr, 1'b0, 1'b0);
      uinstr_slave_enable = 1'b1;
      mst(`MCG_CMD_MST_RD, 1'b0);
      mst(`MCG_CMD_MST_WR, 1'b0);
      mst(`MCG_CMD_MST_RD, 1'b1);
      error_clear = 1'b1;
      tick(2);
      chk("eclear", master_timeout_error, 1'b0);
      conclude;
   end
endmodule
